// ==== include/fault_timing_pkg.sv ====
// constants and types shared by the serial port and fault timing design
package fault_timing_pkg;
  localparam int          WORD_BITS      = 16;
  localparam int          CHANNELS       = 6;
  localparam int          CLK_MHZ        = 250;
  localparam int          OPEN_FILT_US   = 128;
  localparam int          SHORT_BASE_US  = 30;
  localparam int          SAMPLE_US      = 200;
  localparam int          FDBK_VALID_US  = 400;
  localparam int          OPEN_CYC       = OPEN_FILT_US * CLK_MHZ;
  localparam int          SHORT_BASE_CYC = SHORT_BASE_US * CLK_MHZ;
  localparam int          SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;
  localparam int          FDBK_CYC       = FDBK_VALID_US * CLK_MHZ;
  localparam int          CNT_W          = 20;
  localparam logic [2:0]  SHORT_CODE_MAX = 3'h5;
  // command word layout
  localparam int          CMD_ON_LSB     = 0;
  localparam int          CMD_CODE_LSB   = 6;
  localparam int          CMD_SEL_LSB    = 9;
  localparam int          CMD_MEAS_BIT   = 12;
  localparam int          CMD_CAL_BIT    = 13;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [3:0]  BIT_LAST       = 4'hf;
  typedef enum logic [1:0] {
    MEAS_IDLE   = 2'b00,
    MEAS_SAMPLE = 2'b01,
    MEAS_HOLD   = 2'b10
  } meas_state_t;
endpackage

// ==== include/fault_filter_if.sv ====
// bundle between the top and one channel fault filter
`timescale 1ns/100ps
`default_nettype none
interface fault_filter_if;
  logic       drive_on;
  logic       open_cond;
  logic       short_cond;
  logic [2:0] short_code;
  logic       fault;
  modport top  (output drive_on, output open_cond, output short_cond, output short_code,
                input fault);
  modport filt (input drive_on, input open_cond, input short_cond, input short_code,
                output fault);
endinterface
`default_nettype wire

// ==== verilog/fault_filter.sv ====
// one channel open and short persistence filter
`timescale 1ns/100ps
`default_nettype none
module fault_filter (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // channel
  fault_filter_if.filt    ch
);
  logic [fault_timing_pkg::CNT_W-1:0] cnt_reg;
  logic                               fault_reg;
  logic                               cond;
  logic [fault_timing_pkg::CNT_W-1:0] limit;
  logic [fault_timing_pkg::CNT_W-1:0] short_lim;
  logic [2:0]                         code_sat;

  assign code_sat  = (ch.short_code > fault_timing_pkg::SHORT_CODE_MAX) ?
                     fault_timing_pkg::SHORT_CODE_MAX : ch.short_code;
  assign short_lim = fault_timing_pkg::CNT_W'(fault_timing_pkg::SHORT_BASE_CYC) << code_sat;
  assign cond      = ch.drive_on ? ch.short_cond : ch.open_cond;
  assign limit     = ch.drive_on ? short_lim :
                     fault_timing_pkg::CNT_W'(fault_timing_pkg::OPEN_CYC);
  assign ch.fault  = fault_reg;

  always_ff @(posedge core_clk) begin
    if (rst || !cond) begin
      cnt_reg   <= '0;
      fault_reg <= 1'b0;
    end else if (cnt_reg >= limit - 1'b1) begin
      fault_reg <= 1'b1;
    end else begin
      // a flag left from the other drive state must not survive a longer limit
      cnt_reg   <= cnt_reg + 1'b1;
      fault_reg <= 1'b0;
    end
  end

  a_open_persist: assert property (@(posedge core_clk) disable iff (rst)
    $rose(fault_reg) && !ch.drive_on |-> $past(cond) && cnt_reg >= limit - 1'b1)
    else $error("open fault flagged early");
  a_fault_clears: assert property (@(posedge core_clk) disable iff (rst)
    !cond |=> !fault_reg)
    else $error("fault survived cleared condition");
  a_short_persist: assert property (@(posedge core_clk) disable iff (rst)
    fault_reg && ch.drive_on |-> cnt_reg >= short_lim - 1'b1)
    else $error("short fault without full filter time");
endmodule // fault_filter
`default_nettype wire

// ==== verilog/serial_port_fault_timing.sv ====
// serial command port, power modes and driver fault timing
`timescale 1ns/100ps
`default_nettype none
module serial_port_fault_timing (
  // core clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // supplies and enable
  input  wire logic                     logic_supply,
  input  wire logic                     battery_supply,
  input  wire logic                     enable,
  // serial link
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     sdi,
  output logic                          sdo,
  output logic                          sdo_oe,
  // drain sensing per channel
  input  wire logic [5:0]               open_sense,
  input  wire logic [5:0]               short_sense,
  // outputs
  output logic [5:0]                    gate_predriver_outputs,
  output logic                          sleep,
  output logic                          load_sample_active,
  output logic                          load_resistance_output,
  output logic [2:0]                    load_channel,
  output logic                          osc_cal_pulse
);
  // ****************************************************************
  // link domain
  // ****************************************************************
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic        sdo_reg;
  logic [15:0] cmd_link_reg;
  logic [15:0] status_sync_reg;
  logic [3:0]  bitcnt_reg;
  logic        tx_first;

  // count rising clocks of the frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bitcnt_reg <= 4'h0;
    end else begin
      bitcnt_reg <= bitcnt_reg + 4'h1;
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      rx_reg <= {rx_reg[14:0], sdi};
    end
  end

  // status bit 15 is always zero, so the reset value of sdo_reg is the first bit;
  // status_sync_reg is frozen by the core while selected, so it is safe to read here
  assign tx_first = bitcnt_reg == 4'h1;

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_reg  <= fault_timing_pkg::WORD_RESET;
      sdo_reg <= 1'b0;
    end else if (tx_first) begin
      tx_reg  <= {status_sync_reg[13:0], 2'h0};
      sdo_reg <= status_sync_reg[14];
    end else begin
      tx_reg  <= {tx_reg[14:0], 1'b0};
      sdo_reg <= tx_reg[15];
    end
  end

  // serial output straight from the link flop
  assign sdo = sdo_reg;

  // latch command at the rising select edge
  always_ff @(posedge cs_n) begin
    cmd_link_reg <= rx_reg;
  end

  // ****************************************************************
  // core domain crossing
  // ****************************************************************
  logic        cs_d_reg;
  logic [1:0]  cs_sync_reg;
  logic [1:0]  lsup_sync_reg;
  logic [1:0]  bsup_sync_reg;
  logic [1:0]  en_sync_reg;
  logic        lsup_d_reg;
  logic        bsup_d_reg;
  logic [15:0] cmd_reg;
  logic        cmd_new;
  logic        por;

  always_ff @(posedge core_clk) begin
    cs_sync_reg   <= {cs_sync_reg[0], cs_n};
    // held high in reset so no false select edge follows it
    cs_d_reg      <= rst ? 1'b1 : cs_sync_reg[1];
    lsup_sync_reg <= {lsup_sync_reg[0], logic_supply};
    bsup_sync_reg <= {bsup_sync_reg[0], battery_supply};
    en_sync_reg   <= {en_sync_reg[0], enable};
    lsup_d_reg    <= lsup_sync_reg[1];
    bsup_d_reg    <= bsup_sync_reg[1];
  end

  // command word is stable long before the synchronised select edge arrives
  assign cmd_new = cs_sync_reg[1] && !cs_d_reg;
  assign por     = rst || (lsup_sync_reg[1] && !lsup_d_reg) ||
                   (lsup_sync_reg[1] && en_sync_reg[1] && bsup_sync_reg[1] && !bsup_d_reg);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sleep <= 1'b1;
    end else begin
      sleep <= !lsup_sync_reg[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (por || sleep) begin
      cmd_reg <= fault_timing_pkg::WORD_RESET;
    end else if (cmd_new && cs_sync_reg[1]) begin
      cmd_reg <= cmd_link_reg;
    end
  end

  // ****************************************************************
  // fault filters
  // ****************************************************************
  logic [5:0] fault_vec;
  genvar g;
  generate
    for (g = 0; g < fault_timing_pkg::CHANNELS; g++) begin : g_ch
      fault_filter_if ffi ();
      assign ffi.drive_on   = cmd_reg[fault_timing_pkg::CMD_ON_LSB + g];
      assign ffi.open_cond  = open_sense[g];
      assign ffi.short_cond = short_sense[g];
      assign ffi.short_code = cmd_reg[fault_timing_pkg::CMD_CODE_LSB +: 3];
      assign fault_vec[g]   = ffi.fault;
      fault_filter u_filt (
        .core_clk (core_clk),
        .rst      (por),
        .ch       (ffi)
      );
    end
  endgenerate

  // faulted reads as one; held stable for the link
  always_ff @(posedge core_clk) begin
    if (por) begin
      status_sync_reg <= fault_timing_pkg::WORD_RESET;
    end else if (cs_sync_reg[1]) begin
      status_sync_reg <= {10'h000, fault_vec};
    end
  end

  always_ff @(posedge core_clk) begin
    gate_predriver_outputs <= sleep ? 6'h00 : cmd_reg[5:0];
    sdo_oe                 <= !cs_sync_reg[1];
  end

  // ****************************************************************
  // load resistance measurement
  // ****************************************************************
  fault_timing_pkg::meas_state_t meas_reg;
  fault_timing_pkg::meas_state_t meas_next;
  logic [16:0]  mcnt_reg;
  logic         meas_start;
  logic         sample_done;

  assign meas_start  = cmd_new && cs_sync_reg[1] && cmd_link_reg[fault_timing_pkg::CMD_MEAS_BIT];
  assign sample_done = mcnt_reg >= 17'(fault_timing_pkg::SAMPLE_CYC - 1);

  always_comb begin
    meas_next = meas_reg;
    unique case (meas_reg)
      fault_timing_pkg::MEAS_IDLE: begin
        if (meas_start) meas_next = fault_timing_pkg::MEAS_SAMPLE;
      end
      fault_timing_pkg::MEAS_SAMPLE: begin
        if (sample_done) meas_next = fault_timing_pkg::MEAS_HOLD;
      end
      fault_timing_pkg::MEAS_HOLD: begin
        if (meas_start) meas_next = fault_timing_pkg::MEAS_SAMPLE;
      end
      default: meas_next = fault_timing_pkg::MEAS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (por) begin
      meas_reg <= fault_timing_pkg::MEAS_IDLE;
      mcnt_reg <= '0;
    end else begin
      meas_reg <= meas_next;
      mcnt_reg <= (meas_next == fault_timing_pkg::MEAS_SAMPLE &&
                   meas_reg == fault_timing_pkg::MEAS_SAMPLE) ? mcnt_reg + 17'h1 : '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (por) begin
      load_sample_active     <= 1'b0;
      load_resistance_output <= 1'b0;
      load_channel           <= 3'h0;
      osc_cal_pulse          <= 1'b0;
    end else begin
      load_sample_active     <= meas_next == fault_timing_pkg::MEAS_SAMPLE;
      load_resistance_output <= meas_next == fault_timing_pkg::MEAS_HOLD;
      load_channel           <= cmd_reg[fault_timing_pkg::CMD_SEL_LSB +: 3];
      osc_cal_pulse          <= cmd_new && cmd_link_reg[fault_timing_pkg::CMD_CAL_BIT];
    end
  end

  a_sample_bound: assert property (@(posedge core_clk) disable iff (por)
    meas_reg == fault_timing_pkg::MEAS_SAMPLE |->
    mcnt_reg < 17'(fault_timing_pkg::SAMPLE_CYC))
    else $error("sample window overran");
  a_sdo_release: assert property (@(posedge core_clk) disable iff (rst)
    cs_sync_reg[1] |=> !sdo_oe)
    else $error("output driven while deselected");
  a_sleep_mode: assert property (@(posedge core_clk) disable iff (rst)
    !lsup_sync_reg[1] |=> sleep ##1 gate_predriver_outputs == 6'h00)
    else $error("not asleep without logic supply");
endmodule // serial_port_fault_timing
`default_nettype wire

// ==== tb/spi_host.sv ====
// host-side serial master model that drives the link
`timescale 1ns/100ps
`default_nettype none
module spi_host (
  // link
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  logic        link_clk = 1'b0;
  logic        gate     = 1'b0;
  logic        busy     = 1'b0;
  logic [15:0] rx_word  = 16'h0000;
  initial cs_n = 1'b1;
  initial sdi = 1'b0;
  always #7.5 link_clk = ~link_clk;
  // sclk stands low between frames
  assign sclk = link_clk & gate;
  // idle data line never holds a stale bit
  always @(negedge link_clk) if (!busy) sdi = ~sdi;
  // sample on rising edge, msb first
  always @(posedge sclk) if (!cs_n) rx_word <= {rx_word[14:0], sdo};
  // sel low sends the same clocks with select left high
  task automatic send(input logic [15:0] word, input logic sel);
    busy = 1'b1;
    @(negedge link_clk);
    cs_n = ~sel;
    repeat (7) @(negedge link_clk);
    for (int i = 15; i >= 0; i--) begin
      sdi = word[i];
      gate = 1'b1;
      @(negedge link_clk);
    end
    gate = 1'b0;
    repeat (4) @(negedge link_clk);
    cs_n = 1'b1;
    busy = 1'b0;
  endtask
endmodule // spi_host
`default_nettype wire

// ==== tb/serial_port_fault_timing_test.sv ====
// self-checking bench for the serial port and fault timing block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end
module serial_port_fault_timing_test;
  logic core_clk = 1'b0, rst = 1'b1, logic_supply = 1'b0, battery_supply = 1'b0;
  logic enable = 1'b0, sclk, cs_n, sdi, sdo, sdo_oe, sleep, load_sample_active;
  logic load_resistance_output, osc_cal_pulse;
  logic [5:0] open_sense = 6'h00, short_sense = 6'h00, gate_predriver_outputs;
  logic [2:0] load_channel;
  int fails = 0, cmp_count = 0;
  always #2 core_clk = ~core_clk;
  spi_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  serial_port_fault_timing uut (.core_clk(core_clk), .rst(rst), .logic_supply(logic_supply),
    .battery_supply(battery_supply), .enable(enable), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .open_sense(open_sense), .short_sense(short_sense),
    .gate_predriver_outputs(gate_predriver_outputs), .sleep(sleep),
    .load_sample_active(load_sample_active), .load_resistance_output(load_resistance_output),
    .load_channel(load_channel), .osc_cal_pulse(osc_cal_pulse));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // frames keep at least 1 us apart
  task automatic frame(input logic [15:0] w, input logic sel);
    tick(260);
    host.send(w, sel);
  endtask
  task automatic supply(input logic v, input logic b);
    @(posedge core_clk) logic_supply <= v;
    battery_supply <= b;
    enable <= 1'b1;
    tick(12);
  endtask
  task automatic t_command;
    fork
      frame(16'h002a, 1'b1);
      begin tick(300); `CHK(sdo_oe, 1'b1) end
    join
    tick(8);
    `CHK(gate_predriver_outputs, 6'h2a)
    `CHK(sdo_oe, 1'b0)
    frame(16'h0015, 1'b0);
    tick(8);
    `CHK(gate_predriver_outputs, 6'h2a)
  endtask
  task automatic t_calibrate;
    int n = 0;
    frame(16'h2000, 1'b1);
    repeat (20) @(posedge core_clk) n += (osc_cal_pulse === 1'b1);
    `CHK(n, 1)
    `CHK(gate_predriver_outputs, 6'h00)
  endtask
  task automatic t_measure;
    int n = 0, s = 0;
    open_sense <= 6'h15;
    short_sense <= 6'h0a;
    frame(16'h1600, 1'b1);
    while (load_resistance_output !== 1'b1 && n < fault_timing_pkg::FDBK_CYC + 4) begin
      @(posedge core_clk);
      n++;
      s += (load_sample_active === 1'b1);
    end
    `CHK(load_channel, 3'h3)
    `CHK(s > 0 && s <= fault_timing_pkg::SAMPLE_CYC + 2, 1'b1)
    `CHK(load_resistance_output, 1'b1)
  endtask
  task automatic t_power;
    frame(16'h003f, 1'b1);
    tick(8);
    `CHK(gate_predriver_outputs, 6'h3f)
    `CHK(host.rx_word, 16'h0015)
    supply(1'b1, 1'b0);
    supply(1'b1, 1'b1);
    `CHK(gate_predriver_outputs, 6'h00)
    frame(16'h003f, 1'b1);
    supply(1'b0, 1'b1);
    `CHK({sleep, gate_predriver_outputs}, 7'h40)
    supply(1'b1, 1'b1);
    `CHK({sleep, gate_predriver_outputs}, 7'h00)
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(5);
    `CHK(sleep, 1'b1)
    supply(1'b1, 1'b1);
    `CHK({sleep, gate_predriver_outputs}, 7'h00)
    t_command();
    t_calibrate();
    t_measure();
    t_power();
    results();
  end
  // measurement dominates the run, about 52k core cycles; limit at 80k
  initial begin
    #320000;
    fails++;
    results();
  end
endmodule // serial_port_fault_timing_test
`default_nettype wire
